/* srec_regs.svh */
// Register offsets, field positions, reset values and timing figures
// Assumes a 10 MHz clock and an APB slave with 8-bit byte addresses
`ifndef SREC_REGS_SVH
`define SREC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SREC_OFS_CTRL    8'h00
`define SREC_OFS_PD_OUT  8'h04
`define SREC_OFS_ACYC    8'h08
`define SREC_OFS_STATUS  8'h0C
`define SREC_OFS_PD_IN   8'h10

// ----------------------------------------------------------------
// Field positions and command values
// ----------------------------------------------------------------
`define SREC_CTRL_LINK_BIT 0
`define SREC_PD_EN_BIT     0
`define SREC_ACYC_IDX      8'hFA
`define SREC_ACYC_SUB      8'h00

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SREC_RST_WORD  32'h0000_0000
// Arbitrary device information byte
`define SREC_DEV_INFO  8'h5A

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SREC_CLK_HZ     10000000
`define SREC_INT_EN_S   1
`define SREC_FLASH_MS   500
`define SREC_DIAG_BIT_MS 40

`endif

/* srec_pkg.sv */
// Types shared by the enable and start control block
// Assumes srec_regs.svh for all numeric constants
package srec_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_READY,
    ST_ARMED,
    ST_ON,
    ST_FAULT
  } srec_state_e;

  // Pin inputs after synchronisation
  typedef struct packed {
    logic s0_a;
    logic s0_b;
    logic s1_a;
    logic s1_b;
    logic start;
    logic start_src2;
  } srec_pins_s;

endpackage

/* srec_sync.sv */
// Three-stage input synchroniser, one lane per bit
// Assumes asynchronous pin levels and a synchronous-release reset
`timescale 1ns/100ps

module srec_sync
  import srec_pkg::*;
#(
  parameter int W = 6
) (
  input  wire logic         clock,
  input  wire logic         rst_sync_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic f1_q;
      logic f2_q;
      logic f3_q;
      always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          f1_q <= 1'b0;
          f2_q <= 1'b0;
          f3_q <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          f1_q <= d[i];
          f2_q <= f1_q;
          f3_q <= f2_q;
          // Accept a change only once two stages agree
          if (f2_q == f3_q) begin
            q[i] <= f3_q;
          end
        end
      end
    end
  endgenerate

endmodule

/* srec_top.sv */
// Enable, start and indicator control of a two-circuit safety relay
// Assumes an IO-Link stack on APB and 24 V pins level-shifted to logic
`timescale 1ns/100ps

`include "srec_regs.svh"

// Functional notes
// - IO-Link: process byte 0 bit 0 enables
// - Without IO-Link, enable is internal only
// - Acyclic index 250 sub 0 clears mode
// - Boot in cleared mode: internal enable within 1 s
// - Automatic start closes paths at once
// - Manual start closes on button release
// - Power LED steady green when normal
// - Link LED flashes while link is up
// - Link LED off without IO-Link
// - Link LED off when link lost
// - Sensor LED green while circuit closed
// - Relay LEDs green when paths closed
// - Ready state waits for start command
// - Plausibility errors clear only at power-down
// - Process data carries switch and device info
module srec_top
  import srec_pkg::*;
#(
  parameter int INT_EN_CYC = `SREC_INT_EN_S * `SREC_CLK_HZ,
  parameter int FLASH_CYC  = `SREC_CLK_HZ / 1000 * `SREC_FLASH_MS,
  parameter int DIAG_CYC   = `SREC_CLK_HZ / 1000 * `SREC_DIAG_BIT_MS
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        first_sensor_circuit_a,
  input  wire logic        first_sensor_circuit_b,
  input  wire logic        second_sensor_circuit_a,
  input  wire logic        second_sensor_circuit_b,
  input  wire logic        start_input,
  input  wire logic        start_from_second_supply,
  input  wire logic [7:0]  switch_diag,
  input  wire logic        iol_mode_nv,
  output logic             iol_mode_store,
  output logic             first_safety_relay,
  output logic             second_safety_relay,
  output logic             power_led_green,
  output logic             power_led_red,
  output logic             link_activity_led,
  output logic             sensor_led_first,
  output logic             sensor_led_second,
  output logic             relay_led_first,
  output logic             relay_led_second,
  output logic             serial_diag_output
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_b <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  srec_pins_s pins_raw;
  srec_pins_s pins;
  logic [7:0] diag_s;
  logic [1:0] closed;

  assign pins_raw = '{s0_a: first_sensor_circuit_a,
                      s0_b: first_sensor_circuit_b,
                      s1_a: second_sensor_circuit_a,
                      s1_b: second_sensor_circuit_b,
                      start: start_input,
                      start_src2: start_from_second_supply};

  srec_sync #(.W(6)) u_pin_sync (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .d          (pins_raw),
    .q          (pins)
  );

  srec_sync #(.W(8)) u_diag_sync (
    .clock      (clock),
    .rst_sync_b (rst_sync_b),
    .d          (switch_diag),
    .q          (diag_s)
  );

  assign closed[0] = pins.s0_a & pins.s0_b;
  assign closed[1] = pins.s1_a & pins.s1_b;

  // ----------------------------------------------------------------
  // APB register access
  // ----------------------------------------------------------------
  logic        wr_stb;
  logic        rd_setup;
  logic        hit;
  logic        link_up_q;
  logic        link_rise;
  logic        pd_en_q;
  logic        acyc_clr;
  logic        iol_mode_q;
  logic        int_en_q;
  logic        en_q;
  logic        err_q;
  logic        relay_q;
  srec_state_e state_q;
  srec_state_e state_d;

  assign pready   = 1'b1;
  assign wr_stb   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit      = (paddr == `SREC_OFS_CTRL)   ||
                    (paddr == `SREC_OFS_PD_OUT) ||
                    (paddr == `SREC_OFS_ACYC)   ||
                    (paddr == `SREC_OFS_STATUS) ||
                    (paddr == `SREC_OFS_PD_IN);
  assign pslverr  = psel & penable & ~hit;
  assign acyc_clr = wr_stb && (paddr == `SREC_OFS_ACYC) &&
                    (pwdata[7:0] == `SREC_ACYC_IDX) &&
                    (pwdata[15:8] == `SREC_ACYC_SUB);

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      link_up_q <= 1'b0;
      pd_en_q   <= 1'b0;
    end else if (wr_stb && paddr == `SREC_OFS_CTRL) begin
      link_up_q <= pwdata[`SREC_CTRL_LINK_BIT];
    end else if (wr_stb && paddr == `SREC_OFS_PD_OUT) begin
      pd_en_q   <= pwdata[`SREC_PD_EN_BIT];
    end
  end

  // Read data is staged in the setup cycle for a zero-wait access
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prdata <= `SREC_RST_WORD;
    end else if (rd_setup) begin
      case (paddr)
        `SREC_OFS_CTRL:   prdata <= {31'h0, link_up_q};
        `SREC_OFS_PD_OUT: prdata <= {31'h0, pd_en_q};
        `SREC_OFS_STATUS: prdata <= {22'h0, state_q, err_q,
                                     relay_q, en_q, int_en_q,
                                     iol_mode_q, closed};
        `SREC_OFS_PD_IN:  prdata <= {16'h0, `SREC_DEV_INFO,
                                     diag_s};
        default:          prdata <= `SREC_RST_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Operating mode and enable source
  // ----------------------------------------------------------------
  logic        started_q;
  logic        boot_plain_q;
  logic        link_prev_q;
  logic [23:0] int_cnt_q;

  assign link_rise = link_up_q & ~link_prev_q;

  // Stored mode strap is caught on the first cycle after release
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      started_q    <= 1'b0;
      boot_plain_q <= 1'b0;
      link_prev_q  <= 1'b0;
    end else begin
      started_q   <= 1'b1;
      link_prev_q <= link_up_q;
      if (!started_q) begin
        boot_plain_q <= ~iol_mode_nv;
      end
    end
  end

  // Establishing the link wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      iol_mode_q <= 1'b0;
    end else if (!started_q) begin
      iol_mode_q <= iol_mode_nv;
    end else if (link_rise) begin
      iol_mode_q <= 1'b1;
    end else if (acyc_clr) begin
      iol_mode_q <= 1'b0;
    end
  end

  assign iol_mode_store = iol_mode_q;

  // Only a boot with cleared mode starts the internal enable timer
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      int_cnt_q <= 24'h000000;
      int_en_q  <= 1'b0;
    end else if (started_q && boot_plain_q && !iol_mode_q &&
                 !int_en_q) begin
      if (int_cnt_q == 24'(INT_EN_CYC - 1)) begin
        int_en_q <= 1'b1;
      end else begin
        int_cnt_q <= int_cnt_q + 24'h000001;
      end
    end
  end

  // Link loss also withdraws the cyclic enable
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      en_q <= 1'b0;
    end else if (iol_mode_q) begin
      en_q <= pd_en_q & link_up_q;
    end else begin
      en_q <= int_en_q;
    end
  end

  // ----------------------------------------------------------------
  // Plausibility check per sensor circuit
  // ----------------------------------------------------------------
  logic [1:0] circ_a;
  logic [1:0] circ_b;
  logic [1:0] circ_err;

  assign circ_a = {pins.s1_a, pins.s0_a};
  assign circ_b = {pins.s1_b, pins.s0_b};

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_circ
      logic open_a_q;
      logic open_b_q;
      // Reclosing after only one channel opened is a fault
      assign circ_err[c] = circ_a[c] & circ_b[c] &
                           (open_a_q ^ open_b_q);
      always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          open_a_q <= 1'b0;
          open_b_q <= 1'b0;
        end else if (circ_a[c] & circ_b[c]) begin
          open_a_q <= 1'b0;
          open_b_q <= 1'b0;
        end else begin
          open_a_q <= open_a_q | ~circ_a[c];
          open_b_q <= open_b_q | ~circ_b[c];
        end
      end
    end
  endgenerate

  // No software path reaches this flag
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      err_q <= 1'b0;
    end else if (|circ_err) begin
      err_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Start sequence
  // ----------------------------------------------------------------
  logic ok;
  logic auto_s;

  assign ok     = closed[0] & closed[1] & en_q & ~err_q & ~|circ_err;
  assign auto_s = pins.start_src2;

  always_comb begin
    state_d = state_q;
    if (err_q) begin
      state_d = ST_FAULT;
    end else if (!ok) begin
      state_d = ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: begin
          if (auto_s) begin
            state_d = ST_ON;
          end else if (!pins.start) begin
            state_d = ST_READY;
          end
        end
        ST_READY: begin
          if (auto_s) begin
            state_d = ST_ON;
          end else if (pins.start) begin
            state_d = ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (!pins.start) begin
            state_d = ST_ON;
          end
        end
        ST_ON:    state_d = ST_ON;
        default:  state_d = ST_FAULT;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q <= ST_OFF;
      relay_q <= 1'b0;
    end else begin
      state_q <= state_d;
      relay_q <= (state_d == ST_ON);
    end
  end

  assign first_safety_relay  = relay_q;
  assign second_safety_relay = relay_q;
  assign relay_led_first     = relay_q;
  assign relay_led_second    = relay_q;

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  logic [23:0] flash_cnt_q;
  logic        flash_q;
  logic        link_led_q;
  logic [1:0]  sens_led_q;
  logic        pwr_g_q;
  logic        pwr_r_q;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      flash_cnt_q <= 24'h000000;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == 24'(FLASH_CYC - 1)) begin
      flash_cnt_q <= 24'h000000;
      flash_q     <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 24'h000001;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      link_led_q <= 1'b0;
      sens_led_q <= 2'b00;
      pwr_g_q    <= 1'b0;
      pwr_r_q    <= 1'b0;
    end else begin
      // Off both outside IO-Link mode and on link loss
      link_led_q <= iol_mode_q & link_up_q & flash_q;
      sens_led_q <= closed;
      pwr_g_q    <= ~err_q;
      pwr_r_q    <= err_q;
    end
  end

  assign link_activity_led = link_led_q;
  assign sensor_led_first  = sens_led_q[0];
  assign sensor_led_second = sens_led_q[1];
  assign power_led_green   = pwr_g_q;
  assign power_led_red     = pwr_r_q;

  // ----------------------------------------------------------------
  // Serial diagnostic output
  // ----------------------------------------------------------------
  // Bit time well above a 20 ms PLC sampling cycle
  logic [23:0] bit_cnt_q;
  logic [3:0]  bit_idx_q;
  logic [9:0]  frame_q;

  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bit_cnt_q <= 24'h000000;
      bit_idx_q <= 4'h0;
      frame_q   <= 10'h000;
    end else if (bit_cnt_q != 24'(DIAG_CYC - 1)) begin
      bit_cnt_q <= bit_cnt_q + 24'h000001;
    end else begin
      bit_cnt_q <= 24'h000000;
      if (bit_idx_q == 4'h9) begin
        bit_idx_q <= 4'h0;
        frame_q   <= {1'b1, err_q, relay_q, closed, iol_mode_q,
                      link_up_q, en_q, ~err_q, 1'b0};
      end else begin
        bit_idx_q <= bit_idx_q + 4'h1;
        frame_q   <= {frame_q[8:0], 1'b0};
      end
    end
  end

  assign serial_diag_output = frame_q[9];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_b);

  sequence s_clear_cmd;
    started_q && acyc_clr && !link_rise;
  endsequence

  sequence s_armed_release;
    (state_q == ST_ARMED) && ok && !pins.start;
  endsequence

  a_paths_drop: assert property (
    !ok |=> !relay_q)
    else $error("Paths stayed closed after loss");

  a_auto_close: assert property (
    (state_q == ST_OFF) && ok && auto_s |=> relay_q)
    else $error("Automatic start did not close paths");

  a_manual_rel: assert property (
    $rose(relay_q) && !$past(auto_s) |->
      $past(state_q) == ST_ARMED && !$past(pins.start))
    else $error("Manual close without button release");

  a_release_on: assert property (
    s_armed_release |=> relay_q && state_q == ST_ON)
    else $error("Release did not close paths");

  a_pd_gate: assert property (
    iol_mode_q && $past(iol_mode_q) |->
      en_q == $past(pd_en_q && link_up_q))
    else $error("Enable not following process data");

  a_plain_en: assert property (
    !iol_mode_q && !$past(iol_mode_q) |->
      en_q == $past(int_en_q))
    else $error("Enable not internal without link");

  a_acyc_clear: assert property (
    s_clear_cmd |=> !iol_mode_q && !iol_mode_store)
    else $error("Acyclic clear ignored");

  a_int_en_time: assert property (
    (int_cnt_q == 24'(INT_EN_CYC - 1)) && boot_plain_q &&
      !iol_mode_q |=> int_en_q)
    else $error("Internal enable late");

  a_err_latch: assert property (
    err_q |=> err_q && pwr_r_q && !pwr_g_q)
    else $error("Plausibility error cleared");

  a_link_led_off: assert property (
    !(iol_mode_q && link_up_q) |=> !link_activity_led)
    else $error("Link LED lit without link");

  a_ready_wait: assert property (
    (state_q == ST_READY) && !pins.start && !auto_s |=> !relay_q)
    else $error("Ready state closed paths unstarted");

endmodule

/* srec_iol_master.sv */
// IO-Link stack model: APB master for process data and commands
// Assumes srec_regs.svh offsets and a slave on the same clock
`timescale 1ns/100ps

`include "srec_regs.svh"

module srec_iol_master (
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int   tmo_cnt;
  logic last_err;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tmo_cnt = 0;
    last_err = 1'b0;
  end

  // Starts at a fresh edge so no signal is set twice in one step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) tmo_cnt++;
    r        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data lines must not keep the old word
    pwdata  <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0000_0000, r);
  endtask

  task automatic set_enable(input logic en);
    wr(`SREC_OFS_PD_OUT, {31'h0000_0000, en});
  endtask

  task automatic leave_iol();
    wr(`SREC_OFS_ACYC, {16'h0000, `SREC_ACYC_SUB, `SREC_ACYC_IDX});
  endtask
endmodule

/* tb_top.sv */
// Testbench: start modes, IO-Link gating, indicators, fault latch
// Assumes srec_top with shortened counts and the IO-Link stack model
`timescale 1ns/100ps

`include "srec_regs.svh"

module tb_top;
  localparam int INT_EN = 50;
  localparam int FLASH  = 8;

  logic        clock;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  sens;
  logic        start_input;
  logic        start_from_second_supply;
  logic [7:0]  switch_diag;
  logic        iol_mode_nv;
  logic        iol_mode_store;
  logic        first_safety_relay;
  logic        second_safety_relay;
  logic        power_led_green;
  logic        power_led_red;
  logic        link_activity_led;
  logic        sensor_led_first;
  logic        sensor_led_second;
  logic        relay_led_first;
  logic        relay_led_second;
  logic        serial_diag_output;
  logic [31:0] r;
  int          num_errors;
  int          checks_done;

  srec_top #(
    .INT_EN_CYC (INT_EN),
    .FLASH_CYC  (FLASH),
    .DIAG_CYC   (4)
  ) i_srec_top (
    .clock                    (clock),
    .rst_b                    (rst_b),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .first_sensor_circuit_a   (sens[3]),
    .first_sensor_circuit_b   (sens[2]),
    .second_sensor_circuit_a  (sens[1]),
    .second_sensor_circuit_b  (sens[0]),
    .start_input              (start_input),
    .start_from_second_supply (start_from_second_supply),
    .switch_diag              (switch_diag),
    .iol_mode_nv              (iol_mode_nv),
    .iol_mode_store           (iol_mode_store),
    .first_safety_relay       (first_safety_relay),
    .second_safety_relay      (second_safety_relay),
    .power_led_green          (power_led_green),
    .power_led_red            (power_led_red),
    .link_activity_led        (link_activity_led),
    .sensor_led_first         (sensor_led_first),
    .sensor_led_second        (sensor_led_second),
    .relay_led_first          (relay_led_first),
    .relay_led_second         (relay_led_second),
    .serial_diag_output       (serial_diag_output)
  );

  srec_iol_master i_srec_iol_master (
    .clock   (clock),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  always #50 clock = ~clock;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic pick(input int k);
    case (k)
      0: return first_safety_relay;
      1: return link_activity_led;
      default: return power_led_red;
    endcase
  endfunction

  task automatic chk1(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_diag(input int e);
    int n;
    n = 0;
    repeat (40) @(posedge clock);
    repeat (40) begin
      @(posedge clock);
      if (serial_diag_output === 1'b1) n++;
    end
    chkw("diag high", 32'(e), 32'(n));
  endtask

  task automatic chkw(input string n, input logic [31:0] e,
                      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", n, e, g);
    end
  endtask

  // Bounded wait; running out shows up as a mismatch
  task automatic wait_on(input int k, input logic e, input int lim);
    int n;
    n = 0;
    while (pick(k) !== e && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk1("awaited output", e, pick(k));
  endtask

  task automatic boot(input logic nv, input logic aut);
    @(posedge clock);
    rst_b                    <= 1'b0;
    iol_mode_nv              <= nv;
    start_from_second_supply <= aut;
    start_input              <= 1'b0;
    sens                     <= 4'h0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic set_sens(input logic [3:0] v);
    @(posedge clock);
    sens <= v;
  endtask

  task automatic set_start(input logic v);
    @(posedge clock);
    start_input <= v;
  endtask

  task automatic status();
    i_srec_iol_master.rd(`SREC_OFS_STATUS, r);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_auto();
    boot(1'b0, 1'b1);
    set_sens(4'hF);
    wait_on(0, 1'b1, INT_EN + 40);
    repeat (2) @(posedge clock);
    chk1("second relay", 1'b1, second_safety_relay);
    chk1("relay led 1", 1'b1, relay_led_first);
    chk1("relay led 2", 1'b1, relay_led_second);
    chk1("sensor led 1", 1'b1, sensor_led_first);
    chk1("sensor led 2", 1'b1, sensor_led_second);
    chk1("power green", 1'b1, power_led_green);
    chk1("link led", 1'b0, link_activity_led);
    status();
    chkw("status", 32'h0000_01BB, r);
    chk_diag(24);
    i_srec_iol_master.rd(`SREC_OFS_PD_IN, r);
    chkw("pd_in", {16'h0000, `SREC_DEV_INFO, 8'hA5}, r);
    i_srec_iol_master.rd(8'h14, r);
    chk1("unmapped error", 1'b1, i_srec_iol_master.last_err);
    chkw("unmapped data", 32'h0000_0000, r);
    set_sens(4'hC);
    wait_on(0, 1'b0, 8);
    repeat (2) @(posedge clock);
    chk1("sensor led 2 off", 1'b0, sensor_led_second);
    chk1("relay led off", 1'b0, relay_led_first);
    chk1("link led idle", 1'b0, link_activity_led);
  endtask

  task automatic t_manual();
    boot(1'b0, 1'b0);
    set_sens(4'hF);
    repeat (INT_EN + 30) @(posedge clock);
    chk1("relay before start", 1'b0, first_safety_relay);
    status();
    chkw("state ready", 32'h0000_0001, 32'(r[9:7]));
    set_start(1'b1);
    repeat (15) @(posedge clock);
    chk1("relay while pressed", 1'b0, first_safety_relay);
    set_start(1'b0);
    wait_on(0, 1'b1, 10);
  endtask

  task automatic t_iol();
    boot(1'b0, 1'b1);
    set_sens(4'hF);
    i_srec_iol_master.wr(`SREC_OFS_CTRL, 32'h0000_0001);
    repeat (INT_EN + 30) @(posedge clock);
    chk1("relay without pd bit", 1'b0, first_safety_relay);
    status();
    chk1("iol mode", 1'b1, r[2]);
    chk1("mode store", 1'b1, iol_mode_store);
    wait_on(1, 1'b1, 2 * FLASH + 4);
    wait_on(1, 1'b0, FLASH + 4);
    i_srec_iol_master.set_enable(1'b1);
    wait_on(0, 1'b1, 6);
    i_srec_iol_master.wr(`SREC_OFS_PD_OUT, 32'h0000_00FE);
    wait_on(0, 1'b0, 6);
    i_srec_iol_master.set_enable(1'b1);
    wait_on(0, 1'b1, 6);
    i_srec_iol_master.wr(`SREC_OFS_CTRL, 32'h0000_0000);
    wait_on(0, 1'b0, 6);
    repeat (2) @(posedge clock);
    repeat (3 * FLASH) begin
      @(posedge clock);
      chk1("link led lost", 1'b0, link_activity_led);
    end
    i_srec_iol_master.wr(`SREC_OFS_ACYC, 32'h0000_01FA);
    status();
    chk1("mode kept", 1'b1, r[2]);
    i_srec_iol_master.leave_iol();
    status();
    chk1("mode cleared", 1'b0, r[2]);
    chk1("store cleared", 1'b0, iol_mode_store);
    boot(1'b1, 1'b1);
    set_sens(4'hF);
    repeat (INT_EN + 40) @(posedge clock);
    chk1("stored mode holds", 1'b0, first_safety_relay);
    boot(1'b0, 1'b1);
    set_sens(4'hF);
    wait_on(0, 1'b1, INT_EN + 40);
  endtask

  task automatic t_fault();
    boot(1'b0, 1'b1);
    set_sens(4'hF);
    wait_on(0, 1'b1, INT_EN + 40);
    set_sens(4'h7);
    repeat (10) @(posedge clock);
    set_sens(4'hF);
    wait_on(2, 1'b1, 12);
    chk1("green in fault", 1'b0, power_led_green);
    chk1("relay in fault", 1'b0, first_safety_relay);
    set_sens(4'h0);
    repeat (10) @(posedge clock);
    set_sens(4'hF);
    set_start(1'b1);
    repeat (5) @(posedge clock);
    set_start(1'b0);
    repeat (INT_EN) @(posedge clock);
    status();
    chk1("error latched", 1'b1, r[6]);
    chk1("relay stays open", 1'b0, first_safety_relay);
    boot(1'b0, 1'b1);
    repeat (3) @(posedge clock);
    chk1("red after power down", 1'b0, power_led_red);
    chk1("green after power down", 1'b1, power_led_green);
  endtask

  task automatic end_sim();
    num_errors = num_errors + i_srec_iol_master.tmo_cnt;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    sens = 4'h0;
    start_input = 1'b0;
    start_from_second_supply = 1'b1;
    switch_diag = 8'hA5;
    iol_mode_nv = 1'b0;
    num_errors = 0;
    checks_done = 0;
    t_auto();
    t_manual();
    t_iol();
    t_fault();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("BAD run length exp done seen hang");
    end_sim();
  end
endmodule
